// File: design/dfcrc_top.sv
// dual in-line 32-bit frame check generator/checker with register access
// assumes async pins, line clocks far below i_ref_clk
// Operation
// - two independent sections
// - 32-degree code polynomial
// - preset ones, invert before append
// - pass only on fixed residue
// - nine-bit delay on line clock
// - gated clock follows line clock
// - generate codes between two flags
// - closing flag: halt, send code, resume
// - gate high until last code bit
// - strip and stuff zeros, share flags
// - short frame: no code
// - error only on bad residue
// - no error under two bytes
// - seven ones abort, hunt again
// - master reset presets code and pipe
// - wait for whole flag after reset
// - enable low: plain nine-bit delay
// - enable sampled at line rise
// - flag cleared by reset or clear
// - clear pin clears, blocks flag
// - input ignored during code
// - error rises next line edge
// - after abort pass until flag
module dfcrc_top (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_section_master_reset_a,
    input wire logic i_line_clock_in_a,
    input wire logic i_serial_in_a,
    input wire logic i_crc_enable_a,
    input wire logic i_check_generate_select_a,
    input wire logic i_error_flag_clear_a,
    output logic o_gated_clock_out_a,
    output logic o_serial_out_a,
    output logic o_crc_error_flag_a,
    input wire logic i_section_master_reset_b,
    input wire logic i_line_clock_in_b,
    input wire logic i_serial_in_b,
    input wire logic i_crc_enable_b,
    input wire logic i_check_generate_select_b,
    input wire logic i_error_flag_clear_b,
    output logic o_gated_clock_out_b,
    output logic o_serial_out_b,
    output logic o_crc_error_flag_b,
    input wire logic [3:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [3:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready
);
    localparam int N_SEC = 2;
    localparam int SYNC_W = N_SEC * dfcrc_pkg::PINS_PER_SEC;

    typedef struct packed {
        logic awrdy;
        logic wrdy;
        logic arrdy;
        logic aw_got;
        logic w_got;
        logic [3:0] waddr;
        logic [1:0] wbits;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [1:0] soft_clr;
    } dfcrc_axi_type;

    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_sync;
    logic [7:0] status;
    dfcrc_axi_type axi_reg, axi_next;
    dfcrc_line_if #(.N_SEC(N_SEC)) line ();

    // each section's pins kept in its own slice
    assign pins_async = {i_error_flag_clear_b, i_check_generate_select_b, i_crc_enable_b,
        i_serial_in_b, i_line_clock_in_b, i_section_master_reset_b,
        i_error_flag_clear_a, i_check_generate_select_a, i_crc_enable_a,
        i_serial_in_a, i_line_clock_in_a, i_section_master_reset_a};

    dfcrc_sync #(.W(SYNC_W)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async(pins_async),
        .o_sync(pins_sync)
    );

    dfcrc_edge #(.N_SEC(N_SEC)) u_edge (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .line(line.edge_side)
    );

    // restart framing with a fresh code register and flag skip
    function automatic dfcrc_pkg::dfcrc_sec_type start_frame(
            input dfcrc_pkg::dfcrc_sec_type s);
        start_frame = s;
        start_frame.state = dfcrc_pkg::ST_FRAME;
        start_frame.crc = dfcrc_pkg::CRC_INIT;
        start_frame.skip = dfcrc_pkg::FLAG_BITS;
        start_frame.nbits = 5'h0;
        start_frame.emit_idx = 6'h0;
    endfunction : start_frame

    for (genvar k = 0; k < N_SEC; k++) begin : g_sec
        logic [dfcrc_pkg::PINS_PER_SEC-1:0] pin;
        logic [31:0] code;
        logic rise;
        dfcrc_pkg::dfcrc_sec_type cur_reg, cur_next;

        assign pin = pins_sync[k*dfcrc_pkg::PINS_PER_SEC +: dfcrc_pkg::PINS_PER_SEC];
        assign line.lvl[k] = pin[dfcrc_pkg::PIN_CLK];
        assign rise = line.rise[k];
        assign code = ~cur_reg.crc;

        // data sampled two cycles back: stable before the line edge, not after
        always_comb begin
            cur_next = cur_reg;
            cur_next.din_d = {cur_reg.din_d[0], pin[dfcrc_pkg::PIN_DIN]};
            if (rise) begin
                cur_next.en = pin[dfcrc_pkg::PIN_EN];
                cur_next.mode = pin[dfcrc_pkg::PIN_MODE];
                cur_next.chk_bad = 1'b0;
                if (cur_reg.state == dfcrc_pkg::ST_EMIT) begin
                    // controller is frozen, input is left alone
                    if (cur_reg.out_ones == dfcrc_pkg::STUFF_ONES) begin
                        cur_next.out = 1'b0;
                        cur_next.out_ones = 3'h0;
                    end else if (cur_reg.emit_idx != dfcrc_pkg::CODE_BITS) begin
                        cur_next.out = code[cur_reg.emit_idx[4:0]];
                        cur_next.out_ones = code[cur_reg.emit_idx[4:0]] ?
                            dfcrc_pkg::ones_inc(cur_reg.out_ones) : 3'h0;
                        cur_next.emit_idx = 6'(cur_reg.emit_idx + 6'h1);
                    end
                    if (cur_next.emit_idx == dfcrc_pkg::CODE_BITS &&
                            cur_next.out_ones != dfcrc_pkg::STUFF_ONES) begin
                        cur_next = start_frame(cur_next);
                    end
                end else begin
                    // nine-bit pipe: eight stages and the output flop
                    cur_next.sr = {cur_reg.sr[6:0], cur_reg.din_d[1]};
                    cur_next.out = cur_reg.sr[7];
                    cur_next.out_ones = cur_reg.sr[7] ?
                        dfcrc_pkg::ones_inc(cur_reg.out_ones) : 3'h0;
                    cur_next.in_ones = cur_reg.din_d[1] ?
                        dfcrc_pkg::ones_inc(cur_reg.in_ones) : 3'h0;
                    case (cur_reg.state)
                        dfcrc_pkg::ST_HUNT: begin
                            // wait for a whole flag before any computing
                            if (cur_next.en && cur_next.sr == dfcrc_pkg::FLAG_PATTERN) begin
                                cur_next = start_frame(cur_next);
                            end
                        end
                        dfcrc_pkg::ST_FRAME: begin
                            if (!cur_next.en) begin
                                cur_next.state = dfcrc_pkg::ST_HUNT;
                            end else begin
                                // bits leaving the window are past any flag test
                                if (cur_reg.skip != 4'h0) begin
                                    cur_next.skip = 4'(cur_reg.skip - 4'h1);
                                end else if (!cur_reg.sr[7] &&
                                        cur_reg.out_ones == dfcrc_pkg::STUFF_ONES) begin
                                    cur_next.skip = 4'h0;
                                end else begin
                                    cur_next.crc = dfcrc_pkg::crc_step(cur_reg.crc,
                                        cur_reg.sr[7]);
                                    if (cur_reg.nbits != dfcrc_pkg::MIN_BITS) begin
                                        cur_next.nbits = 5'(cur_reg.nbits + 5'h1);
                                    end
                                end
                                if (cur_next.sr == dfcrc_pkg::FLAG_PATTERN) begin
                                    if (cur_next.nbits != dfcrc_pkg::MIN_BITS) begin
                                        cur_next = start_frame(cur_next);
                                    end else if (cur_next.mode) begin
                                        cur_next.chk_bad =
                                            cur_next.crc != dfcrc_pkg::CRC_RESIDUE;
                                        cur_next = start_frame(cur_next);
                                    end else begin
                                        cur_next.state = dfcrc_pkg::ST_EMIT;
                                        cur_next.emit_idx = 6'h0;
                                    end
                                end else if (cur_next.in_ones == dfcrc_pkg::ABORT_ONES) begin
                                    cur_next.state = dfcrc_pkg::ST_HUNT;
                                end
                            end
                        end
                        default: begin
                            cur_next.state = dfcrc_pkg::ST_HUNT;
                        end
                    endcase
                end
            end
            // clear pin wins and blocks; a set beats the software clear
            if (pin[dfcrc_pkg::PIN_CLR]) begin
                cur_next.err = 1'b0;
            end else if (rise && cur_reg.chk_bad) begin
                cur_next.err = 1'b1;
            end else if (axi_reg.soft_clr[k]) begin
                cur_next.err = 1'b0;
            end
            // gate holds high through the whole code
            cur_next.gclk = (cur_next.state == dfcrc_pkg::ST_EMIT) ? 1'b1 :
                pin[dfcrc_pkg::PIN_CLK];
            if (i_rst || pin[dfcrc_pkg::PIN_MR]) begin
                cur_next = dfcrc_pkg::SEC_RESET;
            end
        end

        always_ff @(posedge i_ref_clk) begin
            cur_reg <= cur_next;
        end

        // status bits for software
        assign status[dfcrc_pkg::STAT_ERR_LSB + k] = cur_reg.err;
        assign status[dfcrc_pkg::STAT_FRAME_LSB + k] = cur_reg.state == dfcrc_pkg::ST_FRAME;
        assign status[dfcrc_pkg::STAT_EMIT_LSB + k] = cur_reg.state == dfcrc_pkg::ST_EMIT;
        assign status[dfcrc_pkg::STAT_EN_LSB + k] = cur_reg.en;
    end

    assign o_gated_clock_out_a = g_sec[0].cur_reg.gclk;
    assign o_serial_out_a = g_sec[0].cur_reg.out;
    assign o_crc_error_flag_a = g_sec[0].cur_reg.err;
    assign o_gated_clock_out_b = g_sec[1].cur_reg.gclk;
    assign o_serial_out_b = g_sec[1].cur_reg.out;
    assign o_crc_error_flag_b = g_sec[1].cur_reg.err;

    // word decode ignores the byte offset bits
    function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] off);
        reg_hit = addr[3:2] == off[3:2];
    endfunction : reg_hit

    // register slave: one write and one read in flight at a time
    always_comb begin
        axi_next = axi_reg;
        axi_next.soft_clr = 2'h0;
        if (i_s_axi_awvalid && axi_reg.awrdy) begin
            axi_next.aw_got = 1'b1;
            axi_next.waddr = i_s_axi_awaddr;
            axi_next.awrdy = 1'b0;
        end
        if (i_s_axi_wvalid && axi_reg.wrdy) begin
            axi_next.w_got = 1'b1;
            axi_next.wbits = i_s_axi_wdata[1:0];
            axi_next.wlane0 = i_s_axi_wstrb[0];
            axi_next.wrdy = 1'b0;
        end
        if (axi_reg.aw_got && axi_reg.w_got && !axi_reg.bvalid) begin
            axi_next.aw_got = 1'b0;
            axi_next.w_got = 1'b0;
            axi_next.bvalid = 1'b1;
            axi_next.bresp = dfcrc_pkg::RESP_OKAY;
            if (reg_hit(axi_reg.waddr, dfcrc_pkg::OFF_CTRL)) begin
                axi_next.soft_clr = axi_reg.wlane0 ? axi_reg.wbits : 2'h0;
            end else if (!reg_hit(axi_reg.waddr, dfcrc_pkg::OFF_STATUS)) begin
                axi_next.bresp = dfcrc_pkg::RESP_SLVERR;
            end
        end
        if (axi_reg.bvalid && i_s_axi_bready) begin
            axi_next.bvalid = 1'b0;
            axi_next.awrdy = 1'b1;
            axi_next.wrdy = 1'b1;
        end
        if (i_s_axi_arvalid && axi_reg.arrdy) begin
            axi_next.arrdy = 1'b0;
            axi_next.rvalid = 1'b1;
            axi_next.rresp = dfcrc_pkg::RESP_OKAY;
            axi_next.rdata = 32'h0;
            if (reg_hit(i_s_axi_araddr, dfcrc_pkg::OFF_STATUS)) begin
                axi_next.rdata = {24'h0, status};
            end else if (!reg_hit(i_s_axi_araddr, dfcrc_pkg::OFF_CTRL)) begin
                axi_next.rresp = dfcrc_pkg::RESP_SLVERR;
            end
        end
        if (axi_reg.rvalid && i_s_axi_rready) begin
            axi_next.rvalid = 1'b0;
            axi_next.arrdy = 1'b1;
        end
        if (i_rst) begin
            axi_next = '0;
            axi_next.awrdy = 1'b1;
            axi_next.wrdy = 1'b1;
            axi_next.arrdy = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        axi_reg <= axi_next;
    end

    assign o_s_axi_awready = axi_reg.awrdy;
    assign o_s_axi_wready = axi_reg.wrdy;
    assign o_s_axi_bvalid = axi_reg.bvalid;
    assign o_s_axi_bresp = axi_reg.bresp;
    assign o_s_axi_arready = axi_reg.arrdy;
    assign o_s_axi_rvalid = axi_reg.rvalid;
    assign o_s_axi_rresp = axi_reg.rresp;
    assign o_s_axi_rdata = axi_reg.rdata;
endmodule : dfcrc_top

// File: common/dfcrc_pkg.sv
// constants, state types and helpers shared by the dual frame code block
// assumes one system clock; line clocks arrive as plain sampled inputs
package dfcrc_pkg;

    typedef enum logic [2:0] {
        ST_HUNT = 3'h1,
        ST_FRAME = 3'h2,
        ST_EMIT = 3'h4
    } dfcrc_state_type;

    // framing and code constants
    localparam logic [7:0] FLAG_PATTERN = 8'h7e;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_POLY_REFL = 32'hedb88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
    localparam logic [2:0] ABORT_ONES = 3'h7;
    localparam logic [2:0] STUFF_ONES = 3'h5;
    localparam logic [3:0] FLAG_BITS = 4'h8;
    localparam logic [4:0] MIN_BITS = 5'h10;
    localparam logic [5:0] CODE_BITS = 6'h20;

    // pin positions inside one section's synchronised group
    localparam int PIN_MR = 0;
    localparam int PIN_CLK = 1;
    localparam int PIN_DIN = 2;
    localparam int PIN_EN = 3;
    localparam int PIN_MODE = 4;
    localparam int PIN_CLR = 5;
    localparam int PINS_PER_SEC = 6;

    // register map
    localparam int AXI_ADDR_W = 4;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int STAT_ERR_LSB = 0;
    localparam int STAT_FRAME_LSB = 2;
    localparam int STAT_EMIT_LSB = 4;
    localparam int STAT_EN_LSB = 6;

    typedef struct packed {
        dfcrc_state_type state;
        logic [7:0] sr;
        logic out;
        logic gclk;
        logic [31:0] crc;
        logic [2:0] in_ones;
        logic [2:0] out_ones;
        logic [3:0] skip;
        logic [4:0] nbits;
        logic [5:0] emit_idx;
        logic chk_bad;
        logic err;
        logic en;
        logic mode;
        logic [1:0] din_d;
    } dfcrc_sec_type;

    localparam dfcrc_sec_type SEC_RESET = '{state: ST_HUNT, sr: 8'hff, out: 1'b1,
        gclk: 1'b0, crc: CRC_INIT, in_ones: 3'h0, out_ones: 3'h0, skip: 4'h0,
        nbits: 5'h0, emit_idx: 6'h0, chk_bad: 1'b0, err: 1'b0, en: 1'b0,
        mode: 1'b0, din_d: 2'h0};

    // one serial step of the reflected 32-bit code
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
        crc_step = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY_REFL : 32'h0);
    endfunction : crc_step

    // saturating count of consecutive ones
    function automatic logic [2:0] ones_inc(input logic [2:0] c);
        ones_inc = (c == ABORT_ONES) ? c : 3'(c + 3'h1);
    endfunction : ones_inc

endpackage : dfcrc_pkg

// File: common/dfcrc_line_if.sv
// carries synchronised line clock levels and their rise pulses
// assumes both ends sit on the system clock
interface dfcrc_line_if #(parameter int N_SEC = 2);
    logic [N_SEC-1:0] lvl;
    logic [N_SEC-1:0] rise;
    modport edge_side (input lvl, output rise);
    modport core_side (output lvl, input rise);
endinterface : dfcrc_line_if

// File: design/dfcrc_sync.sv
// two flip-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to i_ref_clk
module dfcrc_sync #(
    parameter int W = 12
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } dfcrc_sync_type;

    dfcrc_sync_type s_reg, s_next;

    // first stage feeds only the second stage
    always_comb begin
        s_next.meta = i_async;
        s_next.stable = s_reg.meta;
        if (i_rst) begin
            s_next = '0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        s_reg <= s_next;
    end

    assign o_sync = s_reg.stable;
endmodule : dfcrc_sync

// File: design/dfcrc_edge.sv
// finds rising edges of the synchronised line clocks
// assumes lvl is already two flops past the pin
module dfcrc_edge #(
    parameter int N_SEC = 2
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    dfcrc_line_if.edge_side line
);
    typedef struct packed {
        logic [N_SEC-1:0] prev;
        logic [N_SEC-1:0] rise;
    } dfcrc_edge_type;

    dfcrc_edge_type e_reg, e_next;

    // registered one-cycle pulse per rise
    always_comb begin
        e_next.prev = line.lvl;
        e_next.rise = line.lvl & ~e_reg.prev;
        if (i_rst) begin
            e_next = '0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        e_reg <= e_next;
    end

    assign line.rise = e_reg.rise;
endmodule : dfcrc_edge

// File: tb/dfcrc_monitor.sv
// checker on the section pins of the frame code block
// assumes the bench keeps mode and enable steady while frames run
module dfcrc_monitor (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_section_master_reset_a,
    input wire logic i_line_clock_in_a,
    input wire logic i_crc_enable_a,
    input wire logic i_check_generate_select_a,
    input wire logic i_error_flag_clear_a,
    input wire logic i_s_axi_wvalid,
    input wire logic o_gated_clock_out_a,
    input wire logic o_serial_out_a,
    input wire logic o_crc_error_flag_a,
    input wire logic i_section_master_reset_b,
    input wire logic o_serial_out_b
);
    logic [6:0] lh;
    logic [6:0] mh;
    // pin history: outputs lag the synchroniser
    always_ff @(posedge i_ref_clk) begin
        lh <= {lh[5:0], i_line_clock_in_a};
        mh <= {mh[5:0], i_section_master_reset_a};
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_clr_held;
        i_error_flag_clear_a [*5];
    endsequence
    // no clear source of any kind, software writes included
    sequence s_quiet;
        !(i_error_flag_clear_a || i_section_master_reset_a || i_s_axi_wvalid) [*6];
    endsequence
    rst_mark_a: assert property ($fell(i_rst) |-> o_serial_out_a && !o_crc_error_flag_a)
        else $error("output not mark after reset");
    flag_sticky_a: assert property (s_quiet |-> !$fell(o_crc_error_flag_a))
        else $error("flag dropped unasked");
    clear_block_a: assert property (s_clr_held |=> !o_crc_error_flag_a)
        else $error("flag high under clear");
    gclk_follow_a: assert property ($fell(o_gated_clock_out_a) |-> !(&lh[3:1]))
        else $error("gated clock fell while line clock high");
    sout_timing_a: assert property ($changed(o_serial_out_a) |-> (|lh[6:1]) || (|mh))
        else $error("serial output moved away from a line edge");
    err_mode_a: assert property ($rose(o_crc_error_flag_a)
        |-> i_check_generate_select_a && (|lh[6:1]))
        else $error("flag rose off check or edge");
    pass_noerr_a: assert property (!i_crc_enable_a [*8] |-> !$rose(o_crc_error_flag_a))
        else $error("error flag rose while disabled");
    mr_mark_b_a: assert property (i_section_master_reset_b [*4] |=> o_serial_out_b)
        else $error("b output not mark in reset");
endmodule : dfcrc_monitor

bind dfcrc_top dfcrc_monitor u_mon (.*);

// File: tb/dfcrc_line_model.sv
// line-side partner: baud clock, controller or modem data, output capture
// assumes the gated clock comes back as the controller's shift clock
module dfcrc_line_model (
    input wire logic i_gclk,
    input wire logic i_dout,
    output logic o_lclk,
    output logic o_din
);
    timeunit 1ns;
    timeprecision 1ns;
    bit q_in[$];
    bit q_out[$];
    // baud clock runs free, 200 ns
    initial o_lclk = 1'b0;
    always #100 o_lclk = ~o_lclk;
    // shifts on the gated clock, so a held clock stalls the sender; idle is mark
    initial o_din = 1'b1;
    always @(posedge i_gclk) o_din <= (q_in.size() > 0) ? q_in.pop_front() : 1'b1;
    // output sampled just as the next line edge arrives, where it is settled
    always @(posedge o_lclk) q_out.push_back(i_dout);
endmodule : dfcrc_line_model

// File: tb/dfcrc_top_test.sv
// self-checking bench for the dual frame code block
// assumes two line models on the sections and an AXI4-Lite master here
module dfcrc_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_ref_clk = 1'b0, i_rst = 1'b1;
    logic i_section_master_reset_a = 1'b1, i_section_master_reset_b = 1'b1;
    logic i_crc_enable_a = 1'b0, i_crc_enable_b = 1'b0;
    logic i_check_generate_select_a = 1'b0, i_check_generate_select_b = 1'b0;
    logic i_error_flag_clear_a = 1'b0, i_error_flag_clear_b = 1'b0;
    logic i_line_clock_in_a, i_line_clock_in_b, i_serial_in_a, i_serial_in_b;
    logic o_gated_clock_out_a, o_serial_out_a, o_crc_error_flag_a;
    logic o_gated_clock_out_b, o_serial_out_b, o_crc_error_flag_b;
    logic [3:0] i_s_axi_awaddr = 4'h0, i_s_axi_araddr = 4'h0, i_s_axi_wstrb = 4'hf;
    logic [31:0] i_s_axi_wdata = 32'h0;
    logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
    logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
    logic [31:0] o_s_axi_rdata;
    logic [7:0] dat [3] = '{8'h12, 8'h34, 8'h56};
    int n_mismatch = 0, checked = 0, hi_run = 0, hi_max = 0;
    bit fr[$];
    logic [31:0] rd;
    logic [1:0] rr;

    always #12.5 i_ref_clk = ~i_ref_clk;
    dfcrc_top DUT (.*);
    dfcrc_line_model m_a (.i_gclk(o_gated_clock_out_a), .i_dout(o_serial_out_a),
        .o_lclk(i_line_clock_in_a), .o_din(i_serial_in_a));
    dfcrc_line_model m_b (.i_gclk(o_gated_clock_out_b), .i_dout(o_serial_out_b),
        .o_lclk(i_line_clock_in_b), .o_din(i_serial_in_b));
    // longest stretch of gated clock high on section a
    always @(posedge i_ref_clk) begin
        hi_run <= o_gated_clock_out_a ? hi_run + 1 : 0;
        if (hi_run > hi_max) hi_max <= hi_run;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // flag, n bytes, optional code (one bit flipped if bad), flag
    task automatic make(input int n, input bit with_fcs, input bit bad);
        logic [31:0] c;
        bit b[$];
        int ones;
        c = 32'hffffffff;
        for (int i = 0; i < 8 * n; i++) begin
            b.push_back(dat[i / 8][i % 8]);
            c = (c >> 1) ^ ((c[0] ^ b[i]) ? 32'hedb88320 : 32'h0);
        end
        if (with_fcs) for (int i = 0; i < 32; i++) b.push_back(~c[i] ^ (bad && i == 0));
        fr = {0, 1, 1, 1, 1, 1, 1, 0};
        ones = 0;
        foreach (b[i]) begin
            fr.push_back(b[i]);
            ones = b[i] ? ones + 1 : 0;
            if (ones == 5) begin
                fr.push_back(1'b0);
                ones = 0;
            end
        end
        fr = {fr, 0, 1, 1, 1, 1, 1, 1, 0};
    endtask : make

    function automatic bit found(input bit h[$], input bit n[$]);
        for (int s = 0; s + n.size() <= h.size(); s++) begin
            found = 1'b1;
            foreach (n[i]) if (h[s + i] != n[i]) found = 1'b0;
            if (found) return 1'b1;
        end
        return 1'b0;
    endfunction : found

    task automatic mode(input bit en, input bit chk);
        @(posedge i_ref_clk);
        i_crc_enable_a <= en;
        i_crc_enable_b <= en;
        i_check_generate_select_a <= chk;
        i_check_generate_select_b <= chk;
        repeat (4) @(posedge i_line_clock_in_a);
    endtask : mode

    // frame, code, stall and pipe delay, in line edges
    task automatic send(input bit sec);
        m_a.q_out = {};
        if (sec) m_b.q_in = fr;
        else m_a.q_in = fr;
        hi_max = 0;
        repeat (fr.size() + 60) @(posedge i_line_clock_in_a);
    endtask : send

    task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge i_ref_clk);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        i_s_axi_bready <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
        end while (o_s_axi_bvalid !== 1'b1);
        r = o_s_axi_bresp;
        i_s_axi_bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_ref_clk);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
        end while (o_s_axi_rvalid !== 1'b1);
        d = o_s_axi_rdata;
        r = o_s_axi_rresp;
        i_s_axi_rready <= 1'b0;
    endtask : axr

    task automatic t_gen;
        bit e[$];
        mode(1'b1, 1'b0);
        make(3, 1'b1, 1'b0);
        e = fr;
        make(3, 1'b0, 1'b0);
        send(1'b0);
        check(32'(found(m_a.q_out, e)), 32'h1);
        check(32'(hi_max > 250), 32'h1);
        make(1, 1'b0, 1'b0);
        send(1'b0);
        check(32'(found(m_a.q_out, fr)), 32'h1);
        check(32'(hi_max < 8), 32'h1);
        mode(1'b0, 1'b0);
        make(3, 1'b0, 1'b0);
        send(1'b0);
        check(32'(found(m_a.q_out, fr)), 32'h1);
        check(32'(hi_max < 8), 32'h1);
        $display("generate and pass tests done");
    endtask : t_gen

    task automatic t_chk;
        mode(1'b1, 1'b1);
        make(3, 1'b1, 1'b0);
        send(1'b0);
        check(32'(o_crc_error_flag_a), 32'h0);
        make(3, 1'b1, 1'b1);
        send(1'b0);
        check(32'(o_crc_error_flag_a), 32'h1);
        make(3, 1'b1, 1'b0);
        send(1'b0);
        check(32'(o_crc_error_flag_a), 32'h1);
        axr(4'h4, rd, rr);
        check(32'(rd[0]), 32'h1);
        axw(4'h0, 32'h1, rr);
        @(negedge i_ref_clk);
        check(32'(rr), 32'h0);
        check(32'(o_crc_error_flag_a), 32'h0);
        axr(4'h8, rd, rr);
        check(32'(rr), 32'h2);
        make(1, 1'b0, 1'b0);
        send(1'b0);
        check(32'(o_crc_error_flag_a), 32'h0);
        make(3, 1'b1, 1'b1);
        repeat (8) void'(fr.pop_back());
        repeat (8) fr.push_back(1'b1);
        send(1'b0);
        check(32'(o_crc_error_flag_a), 32'h0);
        i_error_flag_clear_a <= 1'b1;
        make(3, 1'b1, 1'b1);
        send(1'b0);
        check(32'(o_crc_error_flag_a), 32'h0);
        i_error_flag_clear_a <= 1'b0;
        $display("check tests done");
    endtask : t_chk

    task automatic t_secb;
        make(3, 1'b1, 1'b1);
        send(1'b1);
        check(32'(o_crc_error_flag_b), 32'h1);
        check(32'(o_crc_error_flag_a), 32'h0);
        i_section_master_reset_b <= 1'b1;
        repeat (10) @(posedge i_ref_clk);
        check(32'(o_crc_error_flag_b), 32'h0);
        check(32'(o_serial_out_b), 32'h1);
        i_section_master_reset_b <= 1'b0;
        $display("section b test done");
    endtask : t_secb

    task automatic results;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        i_section_master_reset_a <= 1'b0;
        i_section_master_reset_b <= 1'b0;
        t_gen();
        t_chk();
        t_secb();
        results();
    end
    // tests need well under a millisecond
    initial begin
        #2ms;
        n_mismatch++;
        results();
    end
endmodule : dfcrc_top_test
